// ==== bench/keypad_scan_registers_test.sv ====
// Self-checking bench for the keypad scanner register block
`timescale 1ns/100ps
module keypad_scan_registers_test import kps_pkg::*;;
	logic core_clk, resetn, irq;
	logic kp_tick = 1'b0;
	logic kp_clk_on = 1'b0;
	logic tick_run = 1'b1;
	logic [1:0] ph = 2'd0;
	kps_bus_req_t bus_req = '0;
	logic [7:0] rd_data, d;
	logic [5:0] row_in;
	logic [4:0] col_out;
	logic [29:0] press = 30'h0;
	int err_total = 0;
	int n_checks = 0;
	int cyc = 0;

	kps_top i_kps_top (.core_clk(core_clk), .resetn(resetn), .bus_req(bus_req),
		.rd_data(rd_data), .kp_tick(kp_tick), .kp_clk_on(kp_clk_on), .row_in(row_in),
		.col_out(col_out), .irq(irq));
	kps_keypad i_kps_keypad (.col_drive(col_out), .press(press), .row_sense(row_in));

	// ----------------------------------------------------------------
	// Clock, keypad tick, watchdog
	// ----------------------------------------------------------------
	initial begin
		core_clk = 1'b0;
		forever #2 core_clk = ~core_clk;
	end
	// Tick every 4 cycles stands in for the slow 1 ms tick
	always @(posedge core_clk) begin
		ph <= ph + 2'd1;
		kp_tick <= tick_run && (ph == 2'd3);
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			err_total++;
			stop_test();
		end
	end

	// ----------------------------------------------------------------
	// Shared tasks
	// ----------------------------------------------------------------
	task automatic stop_test();
		if (err_total == 0 && n_checks > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		n_checks++;
		if (got !== exp) begin
			err_total++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic chk_n(input int got, input int exp);
		n_checks++;
		if (got !== exp) begin
			err_total++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		@(posedge core_clk);
		bus_req.addr <= a;
		bus_req.wdata <= v;
		bus_req.wr <= 1'b1;
		@(posedge core_clk);
		bus_req.wr <= 1'b0;
	endtask
	// Read data stand only in the cycle after the strobe
	task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
		@(posedge core_clk);
		bus_req.addr <= a;
		bus_req.rd <= 1'b1;
		@(posedge core_clk);
		bus_req.rd <= 1'b0;
		@(negedge core_clk);
		chk(rd_data, exp);
	endtask
	task automatic settle();
		repeat (3) @(negedge core_clk);
	endtask
	// Counts keypad ticks until the interrupt rises, bounded
	task automatic wait_irq(output int t);
		int n;
		t = 0;
		n = 0;
		while (irq !== 1'b1 && n < 3000) begin
			@(posedge core_clk);
			if (kp_tick === 1'b1) t++;
			n++;
		end
		chk({7'h0, irq}, 8'h01);
	endtask

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task automatic t_reset();
		rchk(8'hd1, 8'h1f);
		rchk(8'hd2, 8'h3f);
		rchk(8'hd3, 8'h00);
		rchk(8'hd4, 8'h00);
		rchk(8'hd0, 8'h00);
		chk({3'h0, col_out}, 8'h1f);
		wr(8'hd2, 8'h00);
		wr(8'hd3, 8'ha6);
		rchk(8'hd2, 8'h3f);
		rchk(8'hd3, 8'ha6);
	endtask
	// Manual scan with the tick stopped
	task automatic t_bypass();
		tick_run <= 1'b0;
		kp_clk_on <= 1'b1;
		wr(8'hd1, 8'h1e);
		settle();
		chk({3'h0, col_out}, 8'h1e);
		press <= 30'h1;
		settle();
		rchk(8'hd2, 8'h3e);
		rchk(8'hd4, 8'h0a);
		chk({7'h0, irq}, 8'h00);
		rchk(8'hd4, 8'h08);
		wr(8'hd4, 8'h01);
		kp_clk_on <= 1'b0;
		wr(8'hd1, 8'h0f);
		settle();
		chk({3'h0, col_out}, 8'h0f);
		rchk(8'hd2, 8'h3f);
		press <= 30'h2000_0000;
		settle();
		chk({7'h0, irq}, 8'h01);
		rchk(8'hd2, 8'h1f);
		rchk(8'hd4, 8'h03);
		settle();
		chk({7'h0, irq}, 8'h00);
		press <= 30'h0;
		wr(8'hd1, 8'h1f);
		wr(8'hd4, 8'h00);
		tick_run <= 1'b1;
	endtask
	// One automatic scan of the key at column 2, row 3
	task automatic hw_run(input logic [7:0] tim, output int tp, output int tr);
		// Columns high first, or the held key would trip the bypass flag early
		wr(8'hd1, 8'h1f);
		wr(8'hd8, 8'hff);
		wr(8'hd3, tim);
		wr(8'hd9, 8'h02);
		press <= 30'h1 << 15;
		@(posedge core_clk iff kp_tick === 1'b1);
		wr(8'hd4, 8'h05);
		wait_irq(tp);
		rchk(8'hd1, 8'h1b);
		rchk(8'hd2, 8'h37);
		rchk(8'hd4, 8'h07);
		chk({7'h0, irq}, 8'h00);
		@(posedge core_clk iff kp_tick === 1'b1);
		press <= 30'h0;
		wait_irq(tr);
		rchk(8'hd8, 8'h03);
		wr(8'hd8, 8'h03);
		rchk(8'hd8, 8'h00);
		wr(8'hd4, 8'h00);
		settle();
		chk({3'h0, col_out}, 8'h1b);
	endtask
	// Press and release times against interval and debounce codes
	task automatic t_timing();
		int tp[6];
		int tr[6];
		logic [7:0] tims[6];
		tims = '{8'h05, 8'h06, 8'h07, 8'h04, 8'h09, 8'h01};
		for (int i = 0; i < 6; i++) begin
			hw_run(tims[i], tp[i], tr[i]);
		end
		chk_n(tp[1] - tp[0], 30);
		chk_n(tp[2] - tp[0], 60);
		chk_n(tp[3] - tp[0], 90);
		chk_n(tp[4] - tp[0], 4);
		chk_n(tp[5] - tp[0], 252);
		chk_n(tr[4] - tr[0], 4);
		chk_n(tr[5] - tr[0], 252);
	endtask
	// Two keys together must not reach the key registers
	task automatic t_multi();
		int t;
		wr(8'hd9, 8'h04);
		press <= 30'h41;
		@(posedge core_clk iff kp_tick === 1'b1);
		wr(8'hd4, 8'h05);
		wait_irq(t);
		rchk(8'hd8, 8'h04);
		rchk(8'hd1, 8'h1b);
		rchk(8'hd4, 8'h05);
		wr(8'hd4, 8'h00);
		press <= 30'h0;
		wr(8'hd8, 8'hff);
		settle();
		chk({7'h0, irq}, 8'h00);
	endtask

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		resetn = 1'b0;
		repeat (4) @(posedge core_clk);
		resetn <= 1'b1;
		t_reset();
		t_bypass();
		t_timing();
		t_multi();
		stop_test();
	end
endmodule

// ==== bench/kps_keypad.sv ====
// Switch matrix model standing on the pin side of the scanner
`timescale 1ns/100ps
module kps_keypad (
	input wire logic [4:0] col_drive, // Column lines from the scanner
	input wire logic [29:0] press, // Closed switches, bit col*6+row
	output logic [5:0] row_sense // Row lines back to the scanner
);
	// ----------------------------------------------------------------
	// Matrix
	// ----------------------------------------------------------------
	// Pull-ups hold a row high; a closed switch only pulls it on a low column
	always_comb begin
		row_sense = 6'h3f;
		for (int c = 0; c < 5; c++) begin
			for (int r = 0; r < 6; r++) begin
				if (press[c * 6 + r] && col_drive[c] === 1'b0) begin
					row_sense[r] = 1'b0;
				end
			end
		end
	end
endmodule

// ==== hdl/kps_params.svh ====
// Offsets, reset values, field positions and counts of the keypad scanner
`ifndef KPS_PARAMS_SVH
`define KPS_PARAMS_SVH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define KPS_OFF_COL 8'hd1
`define KPS_OFF_ROW 8'hd2
`define KPS_OFF_TIM 8'hd3
`define KPS_OFF_STAT 8'hd4
`define KPS_OFF_EVS 8'hd8
`define KPS_OFF_EVM 8'hd9

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define KPS_RST_COL 5'h1f
`define KPS_RST_ROW 6'h3f
`define KPS_RST_TIM 8'h00

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define KPS_STAT_TICK 3
`define KPS_STAT_EN 2
`define KPS_STAT_FLAG 1
`define KPS_STAT_IE 0
`define KPS_TIM_DB_HI 7
`define KPS_TIM_DB_LO 2
`define KPS_TIM_SC_HI 1
`define KPS_TIM_SC_LO 0
`define KPS_EV_FOUND 0
`define KPS_EV_REL 1
`define KPS_EV_MULTI 2

// ----------------------------------------------------------------
// Counts: default interval in 1 ms keypad ticks, last column and row index
// ----------------------------------------------------------------
`define KPS_SC_DEFAULT 9'h004
`define KPS_LAST_COL 3'h4
`define KPS_LAST_ROW 3'h5

`endif

// ==== hdl/kps_pkg.sv ====
// Types shared by the keypad scanner
package kps_pkg;

	// Scanner states, Gray along idle, debounce, scan, release
	typedef enum logic [2:0] {
		KPS_IDLE = 3'b000,
		KPS_DEB_PRESS = 3'b001,
		KPS_SCAN = 3'b011,
		KPS_WAIT_REL = 3'b010,
		KPS_DEB_REL = 3'b110
	} kps_fsm_t;

	// Register port request
	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} kps_bus_req_t;

	// Whole state of the scanner
	typedef struct packed {
		kps_fsm_t fsm;
		logic [8:0] cnt;
		logic [2:0] col_idx;
		logic [2:0] row_idx;
		logic [1:0] hits;
		logic [4:0] fcol;
		logic [5:0] frow;
		logic [4:0] key_column;
		logic [5:0] key_row;
		logic [7:0] timing;
		logic en;
		logic flag;
		logic irq_en;
		logic [2:0] ev;
		logic [2:0] ev_mask;
		logic [5:0] row_s;
		logic all_high_d;
		logic [7:0] rdata;
		logic [4:0] col_out;
		logic irq;
	} kps_state_t;

endpackage

// ==== hdl/kps_top.sv ====
// Keypad matrix scanner with its register port
//
// Functional notes
// - Hardware mode loads column of valid key
// - Bypass mode drives columns from column register
// - Column register active-low, one bit per pin
// - Hardware mode loads row of valid key
// - Row register active-low, one bit per row
// - Debounce field counts 4 ms steps, zero 256
// - Debounce both press and release
// - Scan-time field sets per-key check interval
// - Control/status layout, resets to zero
// - Enable bit selects automatic scan or bypass
// - Key-found flag sets per mode, read clears
// - Interrupt enable gates only the interrupt
// - Bypass detection works without keypad tick
//
// Design decision made here: the address-and-strobe port.
`timescale 1ns/100ps
`include "kps_params.svh"

module kps_top import kps_pkg::*; (
	input wire logic core_clk, // 250 MHz clock
	input wire logic resetn, // Async reset, active low
	input wire kps_bus_req_t bus_req, // Register port request
	output logic [7:0] rd_data, // Read data, cycle after strobe
	input wire logic kp_tick, // 1 ms keypad tick pulse
	input wire logic kp_clk_on, // Keypad clock running
	input wire logic [5:0] row_in, // Row sense lines
	output logic [4:0] col_out, // Column drive lines
	output logic irq // Level interrupt
);

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------

	// No row pulled low
	function automatic logic all_high(input logic [5:0] rows);
		all_high = &rows;
	endfunction

	// Debounce length in ticks; zero means the longest period
	function automatic logic [8:0] deb_ticks(input logic [5:0] field);
		deb_ticks = {(field == 6'h00), field, 2'b00};
	endfunction

	// Per-key interval in ticks
	function automatic logic [8:0] scan_ticks(input logic [1:0] code);
		scan_ticks = (code == 2'b00) ? `KPS_SC_DEFAULT : {7'h00, code};
	endfunction

	kps_state_t s_reg;
	kps_state_t s_next;
	logic flag_set;
	logic [2:0] ev_set;
	logic check_now;
	logic row_low;

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------

	// One pass over bus, scanner, flags and outputs
	always_comb begin
		s_next = s_reg;
		flag_set = 1'b0;
		ev_set = 3'b000;
		check_now = s_reg.fsm == KPS_SCAN && kp_tick && s_reg.cnt == 9'h001;
		row_low = ~s_reg.row_s[s_reg.row_idx];
		s_next.row_s = row_in;
		s_next.all_high_d = all_high(s_reg.row_s);
		s_next.rdata = 8'h00;

		// Register writes; reserved bits are dropped
		if (bus_req.wr) begin
			case (bus_req.addr)
				`KPS_OFF_COL: s_next.key_column = bus_req.wdata[4:0];
				`KPS_OFF_TIM: s_next.timing = bus_req.wdata;
				`KPS_OFF_STAT: begin
					s_next.en = bus_req.wdata[`KPS_STAT_EN];
					s_next.irq_en = bus_req.wdata[`KPS_STAT_IE];
				end
				`KPS_OFF_EVS: s_next.ev = s_reg.ev & ~bus_req.wdata[2:0];
				`KPS_OFF_EVM: s_next.ev_mask = bus_req.wdata[2:0];
				default: ;
			endcase
		end

		// Register reads; unmapped offsets answer zero
		if (bus_req.rd) begin
			case (bus_req.addr)
				`KPS_OFF_COL: s_next.rdata = {3'b000, s_reg.key_column};
				`KPS_OFF_ROW: begin
					// Bypass shows live rows, firmware does the judging
					s_next.rdata = {2'b00, s_reg.en ? s_reg.key_row : s_reg.row_s};
				end
				`KPS_OFF_TIM: s_next.rdata = s_reg.timing;
				`KPS_OFF_STAT: begin
					s_next.rdata = {4'h0, kp_clk_on, s_reg.en, s_reg.flag, s_reg.irq_en};
					s_next.flag = 1'b0;
				end
				`KPS_OFF_EVS: s_next.rdata = {5'h00, s_reg.ev};
				`KPS_OFF_EVM: s_next.rdata = {5'h00, s_reg.ev_mask};
				default: ;
			endcase
		end

		// Scanner; counters step only on keypad ticks, row changes act at once in idle, wait-release and release debounce
		if (!s_reg.en) begin
			s_next.fsm = KPS_IDLE;
		end else begin
			case (s_reg.fsm)
				KPS_IDLE: begin
					if (!all_high(s_reg.row_s)) begin
						s_next.fsm = KPS_DEB_PRESS;
						s_next.cnt = deb_ticks(s_reg.timing[`KPS_TIM_DB_HI:`KPS_TIM_DB_LO]);
					end
				end
				KPS_DEB_PRESS: begin
					if (kp_tick) begin
						if (s_reg.cnt != 9'h001) begin
							s_next.cnt = s_reg.cnt - 9'h001;
						end else if (all_high(s_reg.row_s)) begin
							s_next.fsm = KPS_IDLE;
						end else begin
							s_next.fsm = KPS_SCAN;
							s_next.col_idx = 3'h0;
							s_next.row_idx = 3'h0;
							s_next.hits = 2'b00;
							s_next.cnt = scan_ticks(s_reg.timing[`KPS_TIM_SC_HI:`KPS_TIM_SC_LO]);
						end
					end
				end
				KPS_SCAN: begin
					if (kp_tick && s_reg.cnt != 9'h001) begin
						s_next.cnt = s_reg.cnt - 9'h001;
					end else if (check_now) begin
						// Each row checked after one full interval
						s_next.cnt = scan_ticks(s_reg.timing[`KPS_TIM_SC_HI:`KPS_TIM_SC_LO]);
						if (row_low) begin
							s_next.hits = (s_reg.hits == 2'b00) ? 2'b01 : 2'b10;
							s_next.fcol = ~(5'h01 << s_reg.col_idx);
							s_next.frow = ~(6'h01 << s_reg.row_idx);
						end
						if (s_reg.row_idx != `KPS_LAST_ROW) begin
							s_next.row_idx = s_reg.row_idx + 3'h1;
						end else if (s_reg.col_idx != `KPS_LAST_COL) begin
							s_next.row_idx = 3'h0;
							s_next.col_idx = s_reg.col_idx + 3'h1;
						end else begin
							// Keypad done: only a single key is valid
							s_next.fsm = KPS_WAIT_REL;
							if (s_next.hits == 2'b01) begin
								s_next.key_column = s_next.fcol;
								s_next.key_row = s_next.frow;
								flag_set = 1'b1;
								ev_set[`KPS_EV_FOUND] = 1'b1;
							end else begin
								ev_set[`KPS_EV_MULTI] = 1'b1;
							end
						end
					end
				end
				KPS_WAIT_REL: begin
					if (all_high(s_reg.row_s)) begin
						s_next.fsm = KPS_DEB_REL;
						s_next.cnt = deb_ticks(s_reg.timing[`KPS_TIM_DB_HI:`KPS_TIM_DB_LO]);
					end
				end
				KPS_DEB_REL: begin
					// A bounce restarts the wait for release
					if (!all_high(s_reg.row_s)) begin
						s_next.fsm = KPS_WAIT_REL;
					end else if (kp_tick) begin
						if (s_reg.cnt != 9'h001) begin
							s_next.cnt = s_reg.cnt - 9'h001;
						end else begin
							s_next.fsm = KPS_IDLE;
							ev_set[`KPS_EV_REL] = 1'b1;
						end
					end
				end
				default: s_next.fsm = KPS_IDLE;
			endcase
		end

		// Bypass edge detect needs no tick, so a stopped keypad clock still wakes
		if (!s_reg.en && s_reg.all_high_d && !all_high(s_reg.row_s)) begin
			flag_set = 1'b1;
		end

		// Hardware set wins over the read clear
		if (flag_set) begin
			s_next.flag = 1'b1;
		end
		s_next.ev = s_next.ev | ev_set;

		// Columns: all low while waiting, one low while scanning, register in bypass
		if (!s_next.en) begin
			s_next.col_out = s_next.key_column;
		end else if (s_next.fsm == KPS_SCAN) begin
			s_next.col_out = ~(5'h01 << s_next.col_idx);
		end else begin
			s_next.col_out = 5'h00;
		end

		// Enable gates the interrupt only, never the flag
		s_next.irq = (s_next.flag & s_next.irq_en) | (|(s_next.ev & s_next.ev_mask));
	end

	// ----------------------------------------------------------------
	// State register
	// ----------------------------------------------------------------

	// Registered so every output comes straight from a flop
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			s_reg <= '{fsm: KPS_IDLE, cnt: 9'h000, col_idx: 3'h0, row_idx: 3'h0,
				hits: 2'b00, fcol: `KPS_RST_COL, frow: `KPS_RST_ROW,
				key_column: `KPS_RST_COL, key_row: `KPS_RST_ROW, timing: `KPS_RST_TIM,
				en: 1'b0, flag: 1'b0, irq_en: 1'b0, ev: 3'b000, ev_mask: 3'b000,
				row_s: `KPS_RST_ROW, all_high_d: 1'b1, rdata: 8'h00,
				col_out: `KPS_RST_COL, irq: 1'b0};
		end else begin
			s_reg <= s_next;
		end
	end

	// Outputs
	assign rd_data = s_reg.rdata;
	assign col_out = s_reg.col_out;
	assign irq = s_reg.irq;

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------

	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!resetn);

	// Final check of the last key with exactly one earlier or current hit
	sequence seq_last_check;
		check_now && s_reg.col_idx == `KPS_LAST_COL && s_reg.row_idx == `KPS_LAST_ROW;
	endsequence

	sequence seq_single_key;
		seq_last_check ##0 ((s_reg.hits == 2'b00 && row_low) || (s_reg.hits == 2'b01 && !row_low));
	endsequence

	a_bypass_cols: assert property (!s_reg.en |-> col_out == s_reg.key_column)
		else $error("bypass columns differ from column register");

	a_wait_cols_low: assert property (s_reg.en && s_reg.fsm != KPS_SCAN |-> col_out == 5'h00)
		else $error("columns not all low while waiting");

	a_scan_one_col: assert property (s_reg.fsm == KPS_SCAN |-> $countones(~col_out) == 1)
		else $error("scan drives other than one column low");

	a_valid_load: assert property (s_reg.en ##0 seq_single_key |=>
		s_reg.key_column == $past(s_next.fcol) && s_reg.key_row == $past(s_next.frow) && s_reg.flag)
		else $error("valid key not loaded into key registers");

	a_multi_no_load: assert property (seq_last_check ##0 (s_reg.hits == 2'b10) |=>
		$stable(s_reg.key_column) && $stable(s_reg.key_row))
		else $error("invalid key press updated key registers");

	a_deb_start: assert property ($rose(s_reg.fsm == KPS_DEB_PRESS) |->
		s_reg.cnt == deb_ticks($past(s_reg.timing[7:2])))
		else $error("debounce count loaded wrong");

	a_rel_debounce: assert property (s_reg.en && s_reg.fsm == KPS_DEB_REL && kp_tick &&
		s_reg.cnt == 9'h001 && all_high(s_reg.row_s) |=> s_reg.fsm == KPS_IDLE)
		else $error("release debounce did not finish");

	a_flag_read_clr: assert property (bus_req.rd && bus_req.addr == `KPS_OFF_STAT &&
		!flag_set |=> !s_reg.flag)
		else $error("key-found flag not cleared by read");

	a_bypass_edge: assert property (!s_reg.en && s_reg.all_high_d &&
		!all_high(s_reg.row_s) |=> s_reg.flag ##1 (irq || !s_reg.irq_en || !s_reg.flag))
		else $error("bypass row edge missed");

	a_irq_gate: assert property (!s_reg.irq_en && (s_reg.ev & s_reg.ev_mask) == 3'b000 |->
		!irq)
		else $error("interrupt raised while disabled");

	a_row_live: assert property (bus_req.rd && bus_req.addr == `KPS_OFF_ROW && !s_reg.en |=>
		rd_data == {2'b00, $past(s_reg.row_s)})
		else $error("bypass row read not live rows");

	a_scan_reload: assert property (check_now |=>
		s_reg.cnt == scan_ticks($past(s_reg.timing[1:0])) || s_reg.fsm != KPS_SCAN)
		else $error("per-key interval reloaded wrong");

	// Bus side: data stands one cycle only, unmapped and reserved read zero
	a_rd_idle_zero: assert property (!bus_req.rd |=> rd_data == 8'h00)
		else $error("read data not zero outside read cycle");

	a_unmapped_zero: assert property (bus_req.rd && bus_req.addr != `KPS_OFF_COL &&
		bus_req.addr != `KPS_OFF_ROW && bus_req.addr != `KPS_OFF_TIM &&
		bus_req.addr != `KPS_OFF_STAT && bus_req.addr != `KPS_OFF_EVS &&
		bus_req.addr != `KPS_OFF_EVM |=> rd_data == 8'h00)
		else $error("unmapped offset read not zero");

	a_col_read: assert property (bus_req.rd && bus_req.addr == `KPS_OFF_COL |=>
		rd_data == {3'b000, $past(s_reg.key_column)})
		else $error("column register read wrong");

	a_stat_read: assert property (bus_req.rd && bus_req.addr == `KPS_OFF_STAT |=>
		rd_data[7:4] == 4'h0 && rd_data[2] == $past(s_reg.en) &&
		rd_data[0] == $past(s_reg.irq_en))
		else $error("status register read wrong");

	a_wr_timing: assert property (bus_req.wr && bus_req.addr == `KPS_OFF_TIM |=>
		s_reg.timing == $past(bus_req.wdata))
		else $error("timing register write lost");

	// Scanner steps
	a_en_off_idle: assert property (!s_reg.en |=> s_reg.fsm == KPS_IDLE)
		else $error("scanner not idle in bypass");

	a_idle_wake: assert property (s_reg.en && s_reg.fsm == KPS_IDLE &&
		!all_high(s_reg.row_s) |=> s_reg.fsm == KPS_DEB_PRESS)
		else $error("row low did not start debounce");

	a_press_abort: assert property (s_reg.en && s_reg.fsm == KPS_DEB_PRESS && kp_tick &&
		s_reg.cnt == 9'h001 && all_high(s_reg.row_s) |=> s_reg.fsm == KPS_IDLE)
		else $error("bounced press not dropped");

	a_press_confirm: assert property (s_reg.en && s_reg.fsm == KPS_DEB_PRESS && kp_tick &&
		s_reg.cnt == 9'h001 && !all_high(s_reg.row_s) |=>
		s_reg.fsm == KPS_SCAN && s_reg.col_idx == 3'h0 && s_reg.row_idx == 3'h0)
		else $error("confirmed press did not start scan");

	a_scan_pattern: assert property (s_reg.fsm == KPS_SCAN |->
		col_out == ~(5'h01 << s_reg.col_idx))
		else $error("scan column pattern wrong");

	a_wait_release: assert property (s_reg.en && s_reg.fsm == KPS_WAIT_REL &&
		all_high(s_reg.row_s) |=> s_reg.fsm == KPS_DEB_REL)
		else $error("release did not start debounce");

	a_rel_bounce: assert property (s_reg.en && s_reg.fsm == KPS_DEB_REL &&
		!all_high(s_reg.row_s) |=> s_reg.fsm == KPS_WAIT_REL)
		else $error("release bounce not restarted");

	// Interrupt side
	a_flag_irq: assert property (s_reg.flag && s_reg.irq_en |-> irq)
		else $error("enabled key-found flag gave no interrupt");

	a_ev_set_wins: assert property (ev_set != 3'b000 |=>
		(s_reg.ev & $past(ev_set)) == $past(ev_set))
		else $error("event set lost against clear");

endmodule
